//--- hw/soai_map.svh
// Constants of the overhead and alarm inserter: frame slots, byte values, timing.
// Assumes a 20 MHz reference clock and a short frame of sixteen byte slots.
// Function
// - In set mode the transmitter sends the programmed J0 byte and the receiver reports it.
// - In pass mode the transmitter sends the default J0 of 01 and the receiver reports 01.
// - D7, D8 and D9 are programmed one by one, sent unchanged in set mode and reported alike.
// - In pass mode D7, D8 and D9 are sent as zero and the receiver reads zero.
// - An alarm lasts from 2.5 s upward in steps, or continuously until turned off.
// - While an alarm injection runs, the transmitter shows an active status.
// - Continuous signal loss makes the receiver show LOS, LOF, OOF, B1, B2 and REI.
// - Continuous errored frames make the receiver show LOF, OOF, B1, B2, REI, AIS and RDI.
// - Line FERF makes the receiver show RDI alone, dropping once the injection stops.
// - Line AIS makes the receiver show AIS and REI, with its REI counter still counting.
// - Repeating signal loss turns the receiver indications on and off every 2.5 s.
// - With injection off, a clean signal is sent and all receiver indications go inactive.
// - Two run/stop requests in succession clear all receiver counts and every indication but LOS, which follows the line.
`ifndef SOAI_MAP_SVH
`define SOAI_MAP_SVH

// ----------------------------------------------------------------
// Frame slots
// ----------------------------------------------------------------
`define SOAI_SLOT_A1 4'h0
`define SOAI_SLOT_A2 4'h1
`define SOAI_SLOT_J0 4'h2
`define SOAI_SLOT_B1 4'h3
`define SOAI_SLOT_K2 4'h4
`define SOAI_SLOT_B2 4'h5
`define SOAI_SLOT_M1 4'h6
`define SOAI_SLOT_D7 4'h7
`define SOAI_SLOT_D8 4'h8
`define SOAI_SLOT_D9 4'h9
`define SOAI_SLOT_PAY 4'hA
`define SOAI_SLOT_LAST 4'hF

// ----------------------------------------------------------------
// Byte values and reset values
// ----------------------------------------------------------------
`define SOAI_A1 8'hF6
`define SOAI_A2 8'h28
`define SOAI_J0_DEF 8'h01
`define SOAI_D_DEF 8'h00
`define SOAI_K2_CLEAN 8'h00
`define SOAI_K2_RDI 8'h06
`define SOAI_K2_AIS 8'h07
`define SOAI_M1_CLEAN 8'h00
`define SOAI_M1_REI 8'h01
`define SOAI_LOS_BYTE 8'h00
`define SOAI_ALL_ONES 8'hFF

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SOAI_CLK_KHZ 64'd20000
`define SOAI_SHORT_DUR_MS 64'd2500
`define SOAI_DUR_CONTINUOUS_DURATION 2'h3
`define SOAI_LOF_FRAMES 2'h2

`endif

//--- hw/soai_pkg.sv
// Types of the overhead and alarm inserter.
// Assumes soai_map.svh for all figures.
package soai_pkg;

	// Alarm kinds that the transmitter can inject
	typedef enum logic [2:0] {
		SOAI_ALM_NONE,
		SOAI_ALM_LOS,
		SOAI_ALM_ERR_FRAME,
		SOAI_ALM_FERF,
		SOAI_ALM_AIS,
		SOAI_ALM_REP_LOS
	} soai_alarm_t;

	// Whole state of the block
	typedef struct packed {
		soai_alarm_t alm;
		logic [1:0] alm_left;
		logic [25:0] tick_cnt;
		logic rep_off;
		logic [3:0] slot;
		logic [7:0] tpar1;
		logic [7:0] tpar2;
		logic [7:0] tprev1;
		logic [7:0] tprev2;
		logic [1:0][9:0] buff;
		logic [1:0] buf_cnt;
		logic room;
		logic pay_rdy;
		logic line_vld;
		logic [3:0] rslot;
		logic [7:0] rpar1;
		logic [7:0] rpar2;
		logic [7:0] rprev1;
		logic [7:0] rprev2;
		logic [5:0] fr_err;
		logic [3:0][7:0] cap;
		logic [1:0] oof_run;
		logic [7:0] ind;
		logic [3:0][7:0] shown;
		logic [15:0] cnt_b1;
		logic [15:0] cnt_b2;
		logic [15:0] cnt_rei;
		logic rs_armed;
	} soai_state_t;

endpackage

//--- hw/soai_top.sv
// Transmit overhead insertion with alarm injection, and the matching receive checker.
// Assumes the line loops back: o_line_* is fed to i_rx_* by the surrounding logic.
`include "soai_map.svh"

module soai_top import soai_pkg::*; #(
	parameter int TICK_CYCLES = int'(`SOAI_SHORT_DUR_MS * `SOAI_CLK_KHZ)
) (
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	input wire logic i_j0_set,
	input wire logic [7:0] i_j0_value,
	input wire logic i_dcc_set,
	input wire logic [7:0] i_d7_value,
	input wire logic [7:0] i_d8_value,
	input wire logic [7:0] i_d9_value,
	input wire soai_alarm_t i_alarm_sel,
	input wire logic [1:0] i_alarm_dur,
	input wire logic i_alarm_go,
	input wire logic i_alarm_off,
	input wire logic i_run_stop,
	input wire logic [7:0] i_tx_data,
	input wire logic i_tx_valid,
	output logic o_tx_ready,
	output logic [7:0] o_line_data,
	output logic o_line_sof,
	output logic o_line_loss,
	output logic o_line_valid,
	input wire logic i_line_ready,
	input wire logic [7:0] i_rx_data,
	input wire logic i_rx_sof,
	input wire logic i_rx_loss,
	input wire logic i_rx_valid,
	output logic o_alarm_active,
	output logic [7:0] o_ind,
	output logic [7:0] o_rx_j0,
	output logic [7:0] o_rx_d7,
	output logic [7:0] o_rx_d8,
	output logic [7:0] o_rx_d9,
	output logic [15:0] o_cnt_b1,
	output logic [15:0] o_cnt_b2,
	output logic [15:0] o_cnt_rei
);

	// Indication bits: 0 LOS, 1 LOF, 2 OOF, 3 B1, 4 B2, 5 REI, 6 AIS, 7 RDI
	localparam logic [25:0] TICK_LAST = 26'(TICK_CYCLES - 1);

	soai_state_t s;
	soai_state_t next_s;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		logic tick;
		logic tx_loss;
		logic push;
		logic pop;
		logic [7:0] tb;
		logic [9:0] word;
		logic [1:0] cnt;
		logic [3:0] rs;
		logic [7:0] rb;
		logic [5:0] ferr;
		logic los_now;
		logic clr;
		logic [2:0] add;
		tick = 1'b0;
		tx_loss = 1'b0;
		push = 1'b0;
		pop = 1'b0;
		tb = 8'h00;
		word = 10'h000;
		cnt = 2'h0;
		rs = 4'h0;
		rb = 8'h00;
		ferr = 6'h00;
		los_now = 1'b0;
		clr = 1'b0;
		add = 3'h0;
		next_s = s;

		// Alarm timer: one shared 2.5 s tick, restarted with each injection
		tick = (s.tick_cnt == TICK_LAST);
		next_s.tick_cnt = tick ? 26'h0 : s.tick_cnt + 26'h1;
		if (i_alarm_go) begin
			next_s.alm = i_alarm_sel;
			next_s.alm_left = i_alarm_dur;
			next_s.tick_cnt = 26'h0;
			next_s.rep_off = 1'b0;
		end else if (i_alarm_off) begin
			next_s.alm = SOAI_ALM_NONE;
		end else if (tick && s.alm != SOAI_ALM_NONE) begin
			next_s.rep_off = ~s.rep_off;
			if (s.alm != SOAI_ALM_REP_LOS && s.alm_left != `SOAI_DUR_CONTINUOUS_DURATION) begin
				if (s.alm_left == 2'h0) begin
					next_s.alm = SOAI_ALM_NONE;
				end else begin
					next_s.alm_left = s.alm_left - 2'h1;
				end
			end
		end

		// Byte for the current slot; loss overrides everything with a dark line
		tx_loss = (s.alm == SOAI_ALM_LOS) || (s.alm == SOAI_ALM_REP_LOS && !s.rep_off);
		case (s.slot)
			`SOAI_SLOT_A1: tb = (s.alm == SOAI_ALM_ERR_FRAME) ? ~`SOAI_A1 : `SOAI_A1;
			`SOAI_SLOT_A2: tb = `SOAI_A2;
			`SOAI_SLOT_J0: tb = i_j0_set ? i_j0_value : `SOAI_J0_DEF;
			`SOAI_SLOT_B1: tb = (s.alm == SOAI_ALM_ERR_FRAME) ? ~s.tprev1 : s.tprev1;
			`SOAI_SLOT_K2: begin
				if (s.alm == SOAI_ALM_AIS || s.alm == SOAI_ALM_ERR_FRAME) begin
					tb = `SOAI_K2_AIS;
				end else if (s.alm == SOAI_ALM_FERF) begin
					tb = `SOAI_K2_RDI;
				end else begin
					tb = `SOAI_K2_CLEAN;
				end
			end
			`SOAI_SLOT_B2: tb = (s.alm == SOAI_ALM_ERR_FRAME) ? ~s.tprev2 : s.tprev2;
			`SOAI_SLOT_M1: begin
				if (s.alm == SOAI_ALM_AIS || s.alm == SOAI_ALM_ERR_FRAME) begin
					tb = `SOAI_M1_REI;
				end else begin
					tb = `SOAI_M1_CLEAN;
				end
			end
			`SOAI_SLOT_D7: tb = i_dcc_set ? i_d7_value : `SOAI_D_DEF;
			`SOAI_SLOT_D8: tb = i_dcc_set ? i_d8_value : `SOAI_D_DEF;
			`SOAI_SLOT_D9: tb = i_dcc_set ? i_d9_value : `SOAI_D_DEF;
			default: tb = i_tx_data;
		endcase
		if (tx_loss) begin
			tb = `SOAI_LOS_BYTE;
		end
		word = {tx_loss, (s.slot == `SOAI_SLOT_A1), tb};

		// Overhead slots need only room; payload slots wait for the source too
		push = (s.slot < `SOAI_SLOT_PAY) ? s.room : (s.pay_rdy && i_tx_valid);
		pop = s.line_vld && i_line_ready;
		if (push) begin
			next_s.slot = s.slot + 4'h1;
			next_s.tpar1 = s.tpar1 ^ tb;
			next_s.tpar2 = (s.slot >= `SOAI_SLOT_K2) ? s.tpar2 ^ tb : s.tpar2;
			if (s.slot == `SOAI_SLOT_LAST) begin
				next_s.tprev1 = s.tpar1 ^ tb;
				next_s.tprev2 = s.tpar2 ^ tb;
				next_s.tpar1 = 8'h00;
				next_s.tpar2 = 8'h00;
			end
		end

		// Two-entry buffer: head in entry 0, a stalled receiver just fills entry 1
		cnt = s.buf_cnt;
		if (pop) begin
			next_s.buff[0] = s.buff[1];
			cnt = cnt - 2'h1;
		end
		if (push) begin
			next_s.buff[cnt[0]] = word;
			cnt = cnt + 2'h1;
		end
		next_s.buf_cnt = cnt;
		next_s.room = (cnt != 2'h2);
		next_s.line_vld = (cnt != 2'h0);
		next_s.pay_rdy = (cnt != 2'h2) && (next_s.slot >= `SOAI_SLOT_PAY);

		// Receiver: per-frame checks committed on the last slot
		los_now = i_rx_loss;
		next_s.ind[0] = los_now;
		if (i_rx_valid) begin
			rs = i_rx_sof ? `SOAI_SLOT_A1 : s.rslot;
			rb = i_rx_data;
			ferr = (rs == `SOAI_SLOT_A1) ? 6'h00 : s.fr_err;
			next_s.rslot = rs + 4'h1;
			next_s.rpar1 = (rs == `SOAI_SLOT_A1) ? rb : s.rpar1 ^ rb;
			next_s.rpar2 = (rs >= `SOAI_SLOT_K2) ? s.rpar2 ^ rb : s.rpar2;
			case (rs)
				`SOAI_SLOT_A1: ferr[0] = (rb != `SOAI_A1);
				`SOAI_SLOT_A2: ferr[0] = s.fr_err[0] || (rb != `SOAI_A2);
				`SOAI_SLOT_J0: next_s.cap[0] = rb;
				`SOAI_SLOT_B1: ferr[1] = (rb != s.rprev1);
				`SOAI_SLOT_K2: begin
					ferr[3] = (rb == `SOAI_K2_AIS);
					ferr[4] = (rb == `SOAI_K2_RDI);
				end
				`SOAI_SLOT_B2: ferr[2] = (rb != s.rprev2);
				`SOAI_SLOT_M1: ferr[5] = (rb != `SOAI_M1_CLEAN);
				`SOAI_SLOT_D7: next_s.cap[1] = rb;
				`SOAI_SLOT_D8: next_s.cap[2] = rb;
				`SOAI_SLOT_D9: next_s.cap[3] = rb;
				default: ferr = ferr;
			endcase
			next_s.fr_err = ferr;
			if (rs == `SOAI_SLOT_LAST) begin
				next_s.rprev1 = s.rpar1 ^ rb;
				next_s.rprev2 = s.rpar2 ^ rb;
				next_s.rpar2 = 8'h00;
				if (ferr[0]) begin
					if (s.oof_run != `SOAI_LOF_FRAMES) begin
						next_s.oof_run = s.oof_run + 2'h1;
					end
				end else begin
					next_s.oof_run = 2'h0;
					next_s.shown = s.cap;
				end
				// A dark or unframed line flags parity and far-end errors as well
				next_s.ind[2] = ferr[0];
				next_s.ind[1] = ferr[0] && (s.oof_run == `SOAI_LOF_FRAMES);
				next_s.ind[3] = ferr[1] || ferr[0] || los_now;
				next_s.ind[4] = ferr[2] || ferr[0] || los_now;
				next_s.ind[5] = ferr[5] || ferr[0] || los_now;
				next_s.ind[6] = ferr[3];
				next_s.ind[7] = ferr[4] || (ferr[0] && !los_now);
				add = {ferr[5] || ferr[0] || los_now, ferr[2] || ferr[0] || los_now,
					ferr[1] || ferr[0] || los_now};
			end
		end

		// Run/stop: a second request in a row clears; a count in that cycle survives
		if (i_run_stop) begin
			next_s.rs_armed = ~s.rs_armed;
			clr = s.rs_armed;
		end
		if (clr) begin
			next_s.ind[7:1] = 7'h00;
			next_s.oof_run = 2'h0;
		end
		next_s.cnt_b1 = (clr ? 16'h0 : s.cnt_b1) + {15'h0, add[0]};
		next_s.cnt_b2 = (clr ? 16'h0 : s.cnt_b2) + {15'h0, add[1]};
		next_s.cnt_rei = (clr ? 16'h0 : s.cnt_rei) + {15'h0, add[2]};
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			s <= '0;
			s.alm <= SOAI_ALM_NONE;
			s.room <= 1'b1;
			s.shown[0] <= `SOAI_J0_DEF;
		end else begin
			s <= next_s;
		end
	end

	// ----------------------------------------------------------------
	// Outputs, all straight from the state register
	// ----------------------------------------------------------------
	assign o_tx_ready = s.pay_rdy;
	assign o_line_data = s.buff[0][7:0];
	assign o_line_sof = s.buff[0][8];
	assign o_line_loss = s.buff[0][9];
	assign o_line_valid = s.line_vld;
	assign o_alarm_active = (s.alm != SOAI_ALM_NONE);
	assign o_ind = s.ind;
	assign o_rx_j0 = s.shown[0];
	assign o_rx_d7 = s.shown[1];
	assign o_rx_d8 = s.shown[2];
	assign o_rx_d9 = s.shown[3];
	assign o_cnt_b1 = s.cnt_b1;
	assign o_cnt_b2 = s.cnt_b2;
	assign o_cnt_rei = s.cnt_rei;

endmodule // soai_top

//--- test/soai_asserts.sv
// Port checker for soai_top: alarm timing, dark line, stalls and restart.
// Assumes a bind inside soai_top that hands on its TICK_CYCLES.
module soai_asserts import soai_pkg::*; #(
	parameter int TICK_CYCLES = 200
) (
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	input wire soai_alarm_t i_alarm_sel,
	input wire logic [1:0] i_alarm_dur,
	input wire logic i_alarm_go,
	input wire logic i_alarm_off,
	input wire logic i_run_stop,
	input wire logic [7:0] o_line_data,
	input wire logic o_line_loss,
	input wire logic o_line_valid,
	input wire logic i_line_ready,
	input wire logic i_rx_loss,
	input wire logic o_alarm_active,
	input wire logic [7:0] o_ind,
	input wire logic [15:0] o_cnt_b1,
	input wire logic [15:0] o_cnt_rei
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [31:0] cnt, lim;
	logic half;
	// ------
	// Helper: active cycles since a start, limit 0 when the alarm has no end
	// ------
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			cnt <= '0;
			lim <= '0;
			half <= 1'b0;
		end else begin
			half <= half ^ i_run_stop;
			cnt <= i_alarm_go ? 32'h0 : cnt + 32'(o_alarm_active);
			if (i_alarm_go)
				lim <= (i_alarm_dur == 2'h3 || i_alarm_sel == SOAI_ALM_REP_LOS) ? 32'h0 :
					(32'(i_alarm_dur) + 32'h1) * TICK_CYCLES;
		end
	end
	// ------
	// Properties
	// ------
	default clocking dc @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_b);
	a_start_active: assert property (i_alarm_go && i_alarm_sel != SOAI_ALM_NONE |=> o_alarm_active)
		else $error("start did not raise active");
	a_off_idle: assert property (i_alarm_off && !i_alarm_go |=> !o_alarm_active)
		else $error("off did not drop active");
	a_short_end: assert property (lim != 32'h0 && o_alarm_active |-> cnt < lim)
		else $error("short alarm ran too long");
	a_continuous_duration_hold: assert property (i_alarm_go && i_alarm_dur == 2'h3
		##1 (!i_alarm_off && !i_alarm_go) [*8] |-> o_alarm_active) else $error("continuous ended");
	a_dark_line: assert property (o_line_valid && o_line_loss |-> o_line_data == 8'h00)
		else $error("dark line carries data");
	a_loss_seen: assert property (1'b1 |=> o_ind[0] == $past(i_rx_loss))
		else $error("loss indication does not follow line");
	a_stall_hold: assert property (o_line_valid && !i_line_ready |=> o_line_valid && $stable(o_line_data))
		else $error("stalled word changed");
	a_restart_clear: assert property (half && i_run_stop |=> o_cnt_b1 <= 16'h1 && o_cnt_rei <= 16'h1)
		else $error("second press kept counts");
	c_continuous_duration: cover property (i_alarm_go && i_alarm_dur == 2'h3);
	c_repeat: cover property (i_alarm_go && i_alarm_sel == SOAI_ALM_REP_LOS);
	c_restart: cover property (half && i_run_stop);
endmodule // soai_asserts

//--- test/soai_line_partner.sv
// Far-end line receiver: takes words with random stalls, hands them back as received.
// Assumes the block's clock; each idle cycle inverts the data of the cycle before.
module soai_line_partner (
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	input wire logic [7:0] i_line_data,
	input wire logic i_line_sof,
	input wire logic i_line_loss,
	input wire logic i_line_valid,
	output logic o_line_ready = 1'b0,
	output logic [7:0] o_rx_data = 8'h00,
	output logic o_rx_sof = 1'b0,
	output logic o_rx_loss = 1'b0,
	output logic o_rx_valid = 1'b0
);
	timeunit 1ns;
	timeprecision 1ns;
	int seed = 42;
	// Stalls a quarter of the time so the two-entry buffer fills
	always @(negedge i_ref_clk)
		o_line_ready <= $random(seed) % 4 != 0;
	// Inverted pattern on idle cycles, since a stale byte could pass for a word
	always @(posedge i_ref_clk) begin
		o_rx_valid <= i_rst_b && i_line_valid && o_line_ready;
		o_rx_sof <= i_line_sof && i_line_valid && o_line_ready;
		o_rx_loss <= (i_line_valid && o_line_ready) ? i_line_loss : o_rx_loss;
		o_rx_data <= (i_line_valid && o_line_ready) ? i_line_data : ~o_rx_data;
	end
endmodule // soai_line_partner

//--- test/soai_top_bench.sv
// Bench for soai_top: overhead bytes, alarm durations and effects, payload, restart.
// Assumes the partner loops the line back; the tick is shortened for simulation.
module soai_top_bench import soai_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int TICK = 200;
	logic i_ref_clk = '0, i_rst_b = '0, i_j0_set = '0, i_dcc_set = '0, i_alarm_go = '0;
	logic i_alarm_off = '0, i_run_stop = '0, i_tx_valid = '0, took = '0, pay_on = '0;
	logic [7:0] i_j0_value = '0, i_d7_value = '0, i_d8_value = '0, i_d9_value = '0, i_tx_data = '0;
	logic [1:0] i_alarm_dur = '0;
	soai_alarm_t i_alarm_sel = SOAI_ALM_NONE;
	logic o_tx_ready, o_line_sof, o_line_loss, o_line_valid, i_line_ready, o_alarm_active;
	logic i_rx_sof, i_rx_loss, i_rx_valid;
	logic [7:0] o_line_data, i_rx_data, o_ind, o_rx_j0, o_rx_d7, o_rx_d8, o_rx_d9, ej;
	logic [15:0] o_cnt_b1, o_cnt_b2, o_cnt_rei, c0;
	logic [23:0] ed;
	logic [7:0] oh [16];
	logic [7:0] pay_q [$];
	soai_alarm_t sel_t [4] = '{SOAI_ALM_LOS, SOAI_ALM_ERR_FRAME, SOAI_ALM_FERF, SOAI_ALM_AIS};
	logic [7:0] msk_t [4] = '{8'h3F, 8'h7E, 8'hFF, 8'hFF};
	logic [7:0] exp_t [4] = '{8'h3F, 8'h7E, 8'h80, 8'h60};
	int errors = 0, check_count = 0, seed = 42, slot = 0, n;
	always #25 i_ref_clk = ~i_ref_clk;
	soai_top #(.TICK_CYCLES(TICK)) u_soai_top (.*);
	soai_line_partner u_soai_line_partner (.i_ref_clk, .i_rst_b, .i_line_data(o_line_data),
		.i_line_sof(o_line_sof), .i_line_loss(o_line_loss), .i_line_valid(o_line_valid),
		.o_line_ready(i_line_ready), .o_rx_data(i_rx_data), .o_rx_sof(i_rx_sof),
		.o_rx_loss(i_rx_loss), .o_rx_valid(i_rx_valid));
	// ------
	// Wire model: overhead as sent, payload order kept across stalls
	// ------
	always @(posedge i_ref_clk) begin
		took = i_tx_valid && o_tx_ready;
		if (took)
			pay_q.push_back(i_tx_data);
		if (o_line_valid && i_line_ready) begin
			slot = o_line_sof ? 0 : (slot + 1) % 16;
			if (!o_line_loss)
				oh[slot] = o_line_data;
			// A dark line still consumes its payload byte, so drop it to keep the order
			if (slot >= 10 && pay_q.size() > 0) begin
				if (o_line_loss)
					void'(pay_q.pop_front());
				else
					chk("payload", pay_q.pop_front(), o_line_data);
			end
		end
	end
	// Random payload, held until taken
	always @(negedge i_ref_clk) begin
		if (!i_tx_valid || took) begin
			i_tx_valid <= pay_on && $random(seed) % 2 != 0;
			i_tx_data <= 8'($random(seed));
		end
	end
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic wait_ind(input logic [7:0] mask, input logic [7:0] exp);
		int k;
		for (k = 0; k < 800 && (o_ind & mask) !== exp; k++)
			@(negedge i_ref_clk);
		chk("indications", exp, o_ind & mask);
		if (k == 800)
			end_of_test();
	endtask
	// One-cycle control pulse; bits are run/stop, off and go
	task automatic pulse(input soai_alarm_t sel, input logic [1:0] dur, input logic [2:0] p);
		@(negedge i_ref_clk);
		i_alarm_sel = sel;
		i_alarm_dur = dur;
		{i_run_stop, i_alarm_off, i_alarm_go} = p;
		@(negedge i_ref_clk);
		{i_run_stop, i_alarm_off, i_alarm_go} = 3'h0;
	endtask
	// ------
	// Main sequence
	// ------
	initial begin
		repeat (2) @(negedge i_ref_clk);
		i_rst_b = 1'b1;
		chk("j0 reset", 8'h01, o_rx_j0);
		pay_on = 1'b1;
		// Set with fixed values, pass, then set with random values
		for (int s = 0; s < 3; s++) begin
			{i_j0_set, i_dcc_set} = s == 1 ? 2'h0 : 2'h3;
			{i_j0_value, i_d7_value, i_d8_value, i_d9_value} = s == 0 ? 32'h51AA1105 : $random(seed);
			ej = i_j0_set ? i_j0_value : 8'h01;
			ed = i_dcc_set ? {i_d7_value, i_d8_value, i_d9_value} : 24'h0;
			for (n = 0; n < 800 && {o_rx_j0, o_rx_d7, o_rx_d8, o_rx_d9} !== {ej, ed}; n++)
				@(negedge i_ref_clk);
			chk("wire oh", {ej, ed}, {oh[2], oh[7], oh[8], oh[9]});
			chk("rx oh", {ej, ed}, {o_rx_j0, o_rx_d7, o_rx_d8, o_rx_d9});
			if (n == 800)
				end_of_test();
		end
		// Payload keeps flowing: payload slots wait for the source, so frames need it
		// Short durations end by themselves after whole ticks
		for (int d = 0; d < 2; d++) begin
			pulse(SOAI_ALM_FERF, 2'(d), 3'h1);
			for (n = 0; n < 2000 && o_alarm_active === 1'b1; n++)
				@(negedge i_ref_clk);
			chk("duration", (d + 1) * TICK, n);
		end
		// Continuous alarms last until off, then the line is clean
		for (int a = 0; a < 4; a++) begin
			pulse(sel_t[a], 2'h3, 3'h1);
			wait_ind(msk_t[a], exp_t[a]);
			c0 = o_cnt_rei;
			for (n = 0; n < 600 && o_cnt_rei === c0; n++)
				@(negedge i_ref_clk);
			chk("rei counting", exp_t[a][5], o_cnt_rei !== c0);
			chk("active", 1'b1, o_alarm_active);
			pulse(SOAI_ALM_NONE, 2'h0, 3'h2);
			wait_ind(8'hFF, 8'h00);
			chk("idle", 1'b0, o_alarm_active);
		end
		// Repeating loss comes and goes while the alarm stays on
		pulse(SOAI_ALM_REP_LOS, 2'h0, 3'h1);
		wait_ind(8'h3F, 8'h3F);
		wait_ind(8'h01, 8'h00);
		wait_ind(8'h3F, 8'h3F);
		chk("repeat active", 1'b1, o_alarm_active);
		pulse(SOAI_ALM_NONE, 2'h0, 3'h2);
		wait_ind(8'hFF, 8'h00);
		// One press keeps the counts, the second clears them
		c0 = o_cnt_b1;
		pulse(SOAI_ALM_NONE, 2'h0, 3'h4);
		chk("one press", c0, o_cnt_b1);
		pulse(SOAI_ALM_NONE, 2'h0, 3'h4);
		chk("cleared", 48'h0, {o_cnt_b1, o_cnt_b2, o_cnt_rei});
		end_of_test();
	end
endmodule // soai_top_bench

bind soai_top soai_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_soai_asserts (.i_ref_clk, .i_rst_b,
	.i_alarm_sel, .i_alarm_dur, .i_alarm_go, .i_alarm_off, .i_run_stop, .o_line_data, .o_line_loss,
	.o_line_valid, .i_line_ready, .i_rx_loss, .o_alarm_active, .o_ind, .o_cnt_b1, .o_cnt_rei);
